/* File: hdl/axis_io_pkg.sv */
// Purpose: Constants for the single-axis pulse, encoder and stop logic
// Assumes: 100 MHz system clock, plain register port with word indices
// Notes:   Register indices and field positions are shared with the bench
package axis_io_pkg;
   // Register indices on the plain port
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_STOP = 4'h1;
   localparam logic [3:0] A_HALF = 4'h2;
   localparam logic [3:0] A_CMD  = 4'h3;
   localparam logic [3:0] A_STAT = 4'h4;
   localparam logic [3:0] A_POS  = 4'h5;
   localparam logic [3:0] A_IST  = 4'h6;
   localparam logic [3:0] A_ICLR = 4'h7;
   localparam logic [3:0] A_IEN  = 4'h8;
   // Control fields
   localparam int C_OMODE = 0;  // 2 bits
   localparam int C_ENC   = 2;  // 0 quadrature, 1 up/down
   localparam int C_FLT   = 3;
   localparam int C_HOME  = 4;
   localparam int C_PAGE  = 5;
   localparam int CTRL_W  = 6;
   // Stop configuration fields
   localparam int S_EN    = 0;  // 3 bits
   localparam int S_LVL   = 3;  // 3 bits, 1 = active high
   localparam int S_INST  = 6;  // 3 bits, 1 = instant stop
   localparam int S_LEN   = 9;
   localparam int S_LLVL  = 10;
   localparam int S_LINST = 11;
   localparam int SCFG_W  = 12;
   // Command bits
   localparam int K_PLUS  = 0;
   localparam int K_MINUS = 1;
   localparam int K_DECEL = 2;
   localparam int K_INST  = 3;
   // Output modes
   localparam logic [1:0] OM_PM   = 2'h0;
   localparam logic [1:0] OM_PDIR = 2'h1;
   localparam logic [1:0] OM_QUAD = 2'h2;
   // Input pin slots
   localparam int P_A   = 0;
   localparam int P_B   = 1;
   localparam int P_S0  = 2;
   localparam int P_LMT = 5;
   localparam int NPIN  = 6;
   // Interrupt events
   localparam int I_END  = 0;
   localparam int I_STOP = 1;
   localparam int I_LMT  = 2;
   localparam int NIRQ   = 3;
   // Reset values and timing
   localparam logic [15:0] HALF_RST = 16'h0004;
   localparam logic [1:0]  FLT_MAX  = 2'h3;
endpackage

/* File: hdl/axis_pulse_encoder_stop_io.sv */
// Purpose: Drive pulse output, encoder counting and stop/limit inputs, one axis
// Assumes: All pins asynchronous to clk_i; speed profile lives elsewhere
// Notes:   Decelerating stop finishes the pulse in flight, instant stop cuts it
// Function
// - Both drive pulse outputs stay low during reset and until a drive starts.
// - A running drive gives pulses with equal high and low times.
// - Pulse-plus-direction mode puts pulses on the first output, direction on the second.
// - Quadrature mode puts phase B on the first output and A on the second, so the second leads on a plus drive.
// - Encoder mode decodes A and B into up and down counts of the position.
// - Up/down mode counts up on each rising edge of the first counter input.
// - Up/down mode counts down on each rising edge of the second counter input.
// - Three stop inputs each end a drive, decelerating or instantly.
// - Each stop input has its own enable and active level.
// - Home search may use stop 0 as near home, stop 1 as home, stop 2 as index.
// - Stop input levels read back in the input status register, first page.
// - The plus limit stops a plus drive, decelerating or instantly.
// - Encoder, stop and limit inputs pass an optional integrating filter.
module axis_pulse_encoder_stop_io
   import axis_io_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Pins
   input  wire logic        encoder_phase_a_up_input_i,
   input  wire logic        encoder_phase_b_down_input_i,
   input  wire logic [2:0]  axis_stop_inputs_i,
   input  wire logic        plus_limit_input_i,
   output logic             plus_pulse_output_o,
   output logic             minus_pulse_or_sense_output_o,
   // Unit side
   output logic             near_home_stop_o,
   output logic             home_stop_o,
   output logic             index_stop_o,
   output logic             drive_busy_o,
   output logic             irq_o
);
   import axis_io_pkg::*;

   typedef struct packed {
      logic [NPIN-1:0]      s1, s2;   // Synchroniser stages
      logic [NPIN-1:0][1:0] fc;       // Integrator counters
      logic [NPIN-1:0]      flt, prv;
      logic [CTRL_W-1:0]    ctrl;
      logic [SCFG_W-1:0]    scfg;
      logic [15:0]          half, hc;
      logic [31:0]          pos, rdata;
      logic                 busy, dir, ph, stopping, po, mo;
      logic [1:0]           qd;
      logic [2:0]           hm;
      logic [NIRQ-1:0]      ist, ien;
   } st_t;

   st_t q, d;
   logic [NPIN-1:0] raw;
   logic [2:0]      sact;
   logic            lact, s_any, s_inst, step, up, dn;
   logic [1:0]      om;

   assign raw = {plus_limit_input_i, axis_stop_inputs_i,
                 encoder_phase_b_down_input_i, encoder_phase_a_up_input_i};
   assign om  = q.ctrl[C_OMODE +: 2];

   // Stop and limit qualifiers from filtered levels
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         sact[i] = q.scfg[S_EN+i] & (q.flt[P_S0+i] == q.scfg[S_LVL+i]);
      end
      lact   = q.scfg[S_LEN] & (q.flt[P_LMT] == q.scfg[S_LLVL]) & ~q.dir;
      s_any  = |sact;
      s_inst = |(sact & q.scfg[S_INST +: 3]);
   end

   // Encoder decode; edges come from filtered levels only
   always_comb begin
      up = 1'b0;
      dn = 1'b0;
      if (q.ctrl[C_ENC]) begin
         up = q.flt[P_A] & ~q.prv[P_A];
         dn = q.flt[P_B] & ~q.prv[P_B];
      end else if ((q.flt[P_A] ^ q.prv[P_A]) ^ (q.flt[P_B] ^ q.prv[P_B])) begin
         up = ~(q.prv[P_A] ^ q.flt[P_B]);
         dn = ~up;
      end
   end

   // Next state of the whole axis
   always_comb begin
      d = q;
      d.rdata = 32'h0000_0000;
      // Clear first, so an event of the same cycle sets the bit again
      if (wr_i && addr_i == A_ICLR) begin
         d.ist = q.ist & ~wdata_i[NIRQ-1:0];
      end
      // Two-flop synchroniser, then optional integrator
      d.s1  = raw;
      d.s2  = q.s1;
      d.prv = q.flt;
      for (int i = 0; i < NPIN; i++) begin
         if (!q.ctrl[C_FLT]) begin
            d.flt[i] = q.s2[i];
            d.fc[i]  = 2'h0;
         end else if (q.s2[i] == q.flt[i]) begin
            d.fc[i] = 2'h0;
         end else if (q.fc[i] == FLT_MAX) begin
            d.flt[i] = q.s2[i];
            d.fc[i]  = 2'h0;
         end else begin
            d.fc[i] = q.fc[i] + 2'h1;
         end
      end
      // Position counter; simultaneous up and down cancel
      if (up && !dn) begin
         d.pos = q.pos + 32'h0000_0001;
      end else if (dn && !up) begin
         d.pos = q.pos - 32'h0000_0001;
      end
      // Half-period timer, equal high and low phases
      step = 1'b0;
      if (q.busy) begin
         if (q.hc == 16'h0000) begin
            d.hc = q.half;
            step = 1'b1;
         end else begin
            d.hc = q.hc - 16'h0001;
         end
      end
      if (step) begin
         d.ph = ~q.ph;
         // Phase walks only in its own mode, so a later switch starts from rest
         if (om == OM_QUAD) begin
            d.qd = q.dir ? q.qd - 2'h1 : q.qd + 2'h1;
         end
         // Decelerating stop ends on a whole pulse, never a runt
         if (q.stopping && (om == OM_QUAD || q.ph)) begin
            d.busy       = 1'b0;
            d.stopping   = 1'b0;
            d.ist[I_END] = 1'b1;
         end
      end
      // Stop inputs and plus limit end the drive
      if (q.busy && (s_any || lact)) begin
         if (s_inst || (lact && q.scfg[S_LINST])) begin
            d.busy       = 1'b0;
            d.stopping   = 1'b0;
            d.ph         = 1'b0;
            d.ist[I_END] = 1'b1;
         end else begin
            d.stopping = 1'b1;
         end
         if (s_any) begin
            d.ist[I_STOP] = 1'b1;
         end
         if (lact) begin
            d.ist[I_LMT] = 1'b1;
         end
      end
      // Register writes; interrupt clear loses to a same-cycle event
      if (wr_i) begin
         case (addr_i)
            A_CTRL: d.ctrl = wdata_i[CTRL_W-1:0];
            A_STOP: d.scfg = wdata_i[SCFG_W-1:0];
            A_HALF: d.half = wdata_i[15:0];
            A_POS:  d.pos  = wdata_i;
            A_IEN:  d.ien  = wdata_i[NIRQ-1:0];
            A_CMD: begin
               if (wdata_i[K_INST] && q.busy) begin
                  d.busy       = 1'b0;
                  d.stopping   = 1'b0;
                  d.ph         = 1'b0;
                  d.ist[I_END] = 1'b1;
               end else if (wdata_i[K_DECEL] && q.busy) begin
                  d.stopping = 1'b1;
               end else if (!q.busy && (wdata_i[K_PLUS] || wdata_i[K_MINUS])) begin
                  d.busy     = 1'b1;
                  d.dir      = ~wdata_i[K_PLUS];
                  d.hc       = q.half;
                  d.ph       = 1'b0;
                  d.stopping = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Read path, data stands one cycle only
      if (rd_i) begin
         case (addr_i)
            A_CTRL: d.rdata = {26'h0, q.ctrl};
            A_STOP: d.rdata = {20'h0, q.scfg};
            A_HALF: d.rdata = {16'h0, q.half};
            A_POS:  d.rdata = q.pos;
            A_IST:  d.rdata = {29'h0, q.ist};
            A_IEN:  d.rdata = {29'h0, q.ien};
            A_STAT: begin
               if (!q.ctrl[C_PAGE]) begin
                  d.rdata = {26'h0, q.flt};
               end else begin
                  d.rdata = {29'h0, q.stopping, q.dir, q.busy};
               end
            end
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      // Output pins by the next mode, so pins and a mode write change together
      case (d.ctrl[C_OMODE +: 2])
         OM_PM: begin
            d.po = d.busy & ~d.dir & d.ph;
            d.mo = d.busy & d.dir & d.ph;
         end
         OM_PDIR: begin
            d.po = d.busy & d.ph;
            d.mo = d.dir;
         end
         OM_QUAD: begin
            d.po = d.qd[1];
            d.mo = d.qd[1] ^ d.qd[0];
         end
         default: begin
            d.po = 1'b0;
            d.mo = 1'b0;
         end
      endcase
      // Home search sensors, active levels only when enabled
      d.hm = q.ctrl[C_HOME] ? sact : 3'h0;
      if (srst_i) begin
         d = '0;
         d.half = HALF_RST;
      end
   end

   // One register for the whole state
   always_ff @(posedge clk_i) begin
      q <= d;
   end

   assign rdata_o                       = q.rdata;
   assign plus_pulse_output_o           = q.po;
   assign minus_pulse_or_sense_output_o = q.mo;
   assign near_home_stop_o              = q.hm[0];
   assign home_stop_o                   = q.hm[1];
   assign index_stop_o                  = q.hm[2];
   assign drive_busy_o                  = q.busy;
   assign irq_o                         = |(q.ist & q.ien);

   // Checks
   a_reset_low: assert property (@(posedge clk_i) srst_i |=>
      !plus_pulse_output_o && !minus_pulse_or_sense_output_o && !q.busy)
      else $error("pulse output high after reset");
   a_duty_equal: assert property (@(posedge clk_i) disable iff (srst_i)
      $past(q.busy) && q.busy && $changed(q.ph) |-> q.hc == q.half && $past(q.hc) == 16'h0000)
      else $error("pulse phase length not equal");
   a_pls_dir: assert property (@(posedge clk_i) disable iff (srst_i)
      om == OM_PDIR |-> minus_pulse_or_sense_output_o == q.dir
         && plus_pulse_output_o == (q.busy && q.ph))
      else $error("pulse and direction outputs wrong");
   a_quad_phase: assert property (@(posedge clk_i) disable iff (srst_i)
      om == OM_QUAD && q.busy && !q.dir && $changed(q.qd) |->
         q.qd == $past(q.qd) + 2'h1)
      else $error("quadrature phase order wrong");
   a_enc_step: assert property (@(posedge clk_i) disable iff (srst_i)
      !q.ctrl[C_ENC] && !wr_i && (q.flt[P_A] ^ q.prv[P_A]) && (q.flt[P_B] == q.prv[P_B])
      |=> q.pos != $past(q.pos))
      else $error("encoder edge not counted");
   a_up_count: assert property (@(posedge clk_i) disable iff (srst_i)
      q.ctrl[C_ENC] && !wr_i && q.flt[P_A] && !q.prv[P_A] && !(q.flt[P_B] && !q.prv[P_B])
      |=> q.pos == $past(q.pos) + 32'h0000_0001)
      else $error("up pulse not counted");
   a_dn_count: assert property (@(posedge clk_i) disable iff (srst_i)
      q.ctrl[C_ENC] && !wr_i && q.flt[P_B] && !q.prv[P_B] && !(q.flt[P_A] && !q.prv[P_A])
      |=> q.pos == $past(q.pos) - 32'h0000_0001)
      else $error("down pulse not counted");
   a_stop_inst: assert property (@(posedge clk_i) disable iff (srst_i)
      q.busy && s_inst |=> !q.busy && (om == OM_QUAD || !plus_pulse_output_o))
      else $error("instant stop did not end drive");
   a_lmt_stop: assert property (@(posedge clk_i) disable iff (srst_i)
      q.busy && lact && !wr_i |=> !q.busy || q.stopping)
      else $error("plus limit ignored");
   a_status_page: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == A_STAT && !q.ctrl[C_PAGE] |=> rdata_o[4:2] == $past(q.flt[4:2]))
      else $error("stop levels not on first page");
   a_home_map: assert property (@(posedge clk_i) disable iff (srst_i)
      q.ctrl[C_HOME] && sact[1] |=> $past(q.ctrl[C_HOME]) ? home_stop_o : 1'b1)
      else $error("home sensor not passed on");
   // A drive only ends by a stop, a limit, a command or a finished decel
   a_drive_holds: assert property (@(posedge clk_i) disable iff (srst_i)
      q.busy && !q.stopping && !s_any && !lact && !wr_i |=> q.busy)
      else $error("drive ended without cause");
   a_minus_limit: assert property (@(posedge clk_i) disable iff (srst_i)
      q.busy && q.dir |-> !lact)
      else $error("plus limit acted on minus drive");
   a_filter_off: assert property (@(posedge clk_i) disable iff (srst_i)
      !q.ctrl[C_FLT] |=> q.flt == $past(q.s2))
      else $error("unfiltered level not passed on");
   a_mode_low: assert property (@(posedge clk_i) disable iff (srst_i)
      om == 2'h3 |-> !plus_pulse_output_o && !minus_pulse_or_sense_output_o)
      else $error("outputs high in quiet mode");
endmodule

/* File: test/motor_field_model.sv */
// Purpose: Far side model: encoder, stop and limit sensors, pulse counter
// Assumes: Requests from the bench change just after a rising edge
// Notes:   Quadrature steps advance on the rising edge of a request
module motor_field_model (
   // Clock
   input  wire logic       clk_i,
   // Requests from the bench
   input  wire logic       ud_i,
   input  wire logic       up_i,
   input  wire logic       dn_i,
   input  wire logic [3:0] sens_i,
   // Pins
   input  wire logic       pulse_i,
   output logic            a_o,
   output logic            b_o,
   output logic [3:0]      sens_o,
   output int              pulses_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph_q = 2'h0;
   logic       up_q = 1'b0;
   logic       dn_q = 1'b0;
   logic       p_q  = 1'b0;
   int         cnt_q = 0;
   assign pulses_o = cnt_q;
   // Bench holds every sensor level far longer than two clocks
   assign sens_o = sens_i;
   // Up/down copies the request; quadrature lets A lead B going up
   assign a_o = ud_i ? up_i : ph_q[1] ^ ph_q[0];
   assign b_o = ud_i ? dn_i : ph_q[1];
   // Step walker and drive pulse counter
   always @(posedge clk_i) begin
      up_q <= up_i;
      dn_q <= dn_i;
      p_q  <= pulse_i;
      if (!ud_i && up_i && !up_q) ph_q <= ph_q + 2'h1;
      if (!ud_i && dn_i && !dn_q) ph_q <= ph_q - 2'h1;
      if (pulse_i && !p_q) cnt_q <= cnt_q + 1;
   end
endmodule

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the single-axis pulse, encoder, stop logic
// Assumes: Random halves and step counts from a fixed seed
// Notes:   Inputs change by non-blocking assignment at the rising edge
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin errors++; \
   $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import axis_io_pkg::*;
   logic        clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [3:0]  addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        ud_i = 1'b0;
   logic        up_i = 1'b0;
   logic        dn_i = 1'b0;
   logic [3:0]  sens_i = 4'h0;
   logic [31:0] rdata_o;
   logic [3:0]  sens;
   logic        pin_a, pin_b, pp, pm, nh, hm, ix, busy, irq;
   logic [31:0] v;
   int          pulses, errors = 0, samples_checked = 0, cyc = 0, h, hi, lo, n, k;
   always #5 clk_i = ~clk_i;
   axis_pulse_encoder_stop_io dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .encoder_phase_a_up_input_i(pin_a), .encoder_phase_b_down_input_i(pin_b),
      .axis_stop_inputs_i(sens[2:0]), .plus_limit_input_i(sens[3]),
      .plus_pulse_output_o(pp), .minus_pulse_or_sense_output_o(pm),
      .near_home_stop_o(nh), .home_stop_o(hm), .index_stop_o(ix),
      .drive_busy_o(busy), .irq_o(irq));
   motor_field_model model (.clk_i(clk_i), .ud_i(ud_i), .up_i(up_i), .dn_i(dn_i),
      .sens_i(sens_i), .pulse_i(pp), .a_o(pin_a), .b_o(pin_b), .sens_o(sens),
      .pulses_o(pulses));
   // Register port master
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic chk_reg(input string nm, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      `CHK(nm, e, d)
   endtask
   // Let a register write land before looking at levels
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_busy(input logic e, input int lim);
      repeat (lim) if (busy !== e) @(posedge clk_i);
      `CHK("drive busy", e, busy)
   endtask
   // One sensor step, held for a number of clocks, then a quiet gap
   task automatic step(input logic up, input int hold);
      @(posedge clk_i);
      if (up) up_i <= 1'b1;
      else dn_i <= 1'b1;
      repeat (hold) @(posedge clk_i);
      up_i <= 1'b0;
      dn_i <= 1'b0;
      repeat (12) @(posedge clk_i);
   endtask
   // Widths of one high and the following low phase of the first output
   task automatic phases(output int hi_n, output int lo_n);
      hi_n = 0;
      lo_n = 0;
      while (pp !== 1'b1) @(posedge clk_i);
      while (pp === 1'b1) begin hi_n++; @(posedge clk_i); end
      while (pp === 1'b0) begin lo_n++; @(posedge clk_i); end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, far above the twelve hundred or so clocks the tests need at most
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(54));
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      #1 `CHK("idle outputs", 2'h0, {pp, pm})
      chk_reg("half reset", A_HALF, {16'h0, HALF_RST});
      chk_reg("unmapped", 4'hF, 32'h0);
      $display("reset test done");
      // Plus drive on plus/minus mode, minus drive on pulse plus direction
      for (int m = 0; m < 2; m++) begin
         h = $urandom_range(1, 5);
         wr_reg(A_CTRL, 32'(m));
         wr_reg(A_HALF, 32'(h));
         wr_reg(A_CMD, 32'h1 << (m ? K_MINUS : K_PLUS));
         phases(hi, lo);
         `CHK("high time", h + 1, hi)
         `CHK("low time", h + 1, lo)
         `CHK("second output", m[0], pm)
         wr_reg(A_CMD, 32'h1 << K_INST);
         wait_busy(1'b0, 20);
      end
      `CHK("pulses seen", 1'b1, pulses > 2)
      wr_reg(A_CTRL, {30'h0, OM_QUAD});
      wr_reg(A_CMD, 32'h1 << K_PLUS);
      n = 0;
      while ({pp, pm} === 2'h0 && n < 50) begin n++; @(posedge clk_i); end
      `CHK("quad first step", 2'h1, {pp, pm})
      wr_reg(A_CMD, 32'h1 << K_INST);
      wr_reg(A_CTRL, 32'h3);
      settle();
      `CHK("mode three low", 2'h0, {pp, pm})
      $display("pulse output test done");
      // Encoder counting in both input modes
      for (int e = 0; e < 2; e++) begin
         ud_i <= e[0];
         wr_reg(A_CTRL, 32'(e) << C_ENC);
         repeat (8) @(posedge clk_i);
         wr_reg(A_POS, 32'h0);
         n = $urandom_range(1, 12);
         k = $urandom_range(0, 12);
         repeat (n) step(1'b1, 4);
         repeat (k) step(1'b0, 4);
         chk_reg("position", A_POS, 32'(n - k));
      end
      // A short glitch is swallowed while the filter is on
      wr_reg(A_CTRL, (32'h1 << C_ENC) | (32'h1 << C_FLT));
      wr_reg(A_POS, 32'h0);
      step(1'b1, 2);
      step(1'b1, 8);
      chk_reg("filtered position", A_POS, 32'h1);
      $display("encoder test done");
      // Stop 1 enabled, active high, instant; stop 2 left disabled
      wr_reg(A_CTRL, 32'h1 << C_HOME);
      wr_reg(A_STOP, (32'h2 << S_EN) | (32'h2 << S_LVL) | (32'h2 << S_INST));
      wr_reg(A_CMD, 32'h1 << K_PLUS);
      sens_i <= 4'h4;
      repeat (20) @(posedge clk_i);
      `CHK("busy past disabled stop", 1'b1, busy)
      sens_i <= 4'h6;
      wait_busy(1'b0, 12);
      repeat (2) @(posedge clk_i);
      `CHK("outputs after stop", 2'h0, {pp, pm})
      `CHK("home outputs", 3'h2, {ix, hm, nh})
      chk_reg("input levels", A_STAT, 32'h18);
      rd_reg(A_IST, v);
      `CHK("stop event", 1'b1, v[I_STOP])
      `CHK("irq masked", 1'b0, irq)
      wr_reg(A_IEN, 32'h1 << I_STOP);
      settle();
      `CHK("irq enabled", 1'b1, irq)
      sens_i <= 4'h0;
      repeat (8) @(posedge clk_i);
      wr_reg(A_ICLR, 32'h1 << I_STOP);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      $display("stop input test done");
      // Plus limit, decelerating: ignored by a minus drive
      wr_reg(A_STOP, (32'h1 << S_LEN) | (32'h1 << S_LLVL));
      wr_reg(A_CTRL, 32'h1 << C_PAGE);
      wr_reg(A_CMD, 32'h1 << K_MINUS);
      sens_i <= 4'h8;
      repeat (20) @(posedge clk_i);
      `CHK("minus drive at limit", 1'b1, busy)
      chk_reg("drive status", A_STAT, 32'h3);
      wr_reg(A_CMD, 32'h1 << K_DECEL);
      wait_busy(1'b0, 20);
      `CHK("outputs after decel", 2'h0, {pp, pm})
      wr_reg(A_CMD, 32'h1 << K_PLUS);
      settle();
      wait_busy(1'b0, 4 * (h + 1) + 20);
      rd_reg(A_IST, v);
      `CHK("limit event", 1'b1, v[I_LMT])
      sens_i <= 4'h0;
      $display("limit test done");
      report_and_stop();
   end
endmodule
